// ===== testbench.sv
// testbench.sv: register-level tests of the watchdog reset timer
// assumes: dividers shortened to 8 and 4, pulse to 8; slow clocks made here
`timescale 1ns/1ps
`include "wdrt_map.vh"
module testbench;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        ext_reset_pin_n = 1'b1;
  logic [2:0]  power_mode = 3'h0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  div_ff = 4'h0;
  logic [7:0]  rd_val;
  logic [7:0]  hold_val;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         chip_reset_n;
  wire         watchdog_reset_flag;
  wire         watchdog_running;
  int          err_total = 0;
  int          check_count = 0;
  int          t_start;
  int          t_low;

  always #2 core_clk = ~core_clk;
  // subclock is core/16, oscillator core/4
  always @(posedge core_clk) div_ff <= div_ff + 4'h1;

  wdrt_watchdog_reset_timer #(.SYS_DIV(8), .SUB_DIV(4), .RST_PULSE(8)) DUT
  (
    .core_clk(core_clk), .arst_n(arst_n), .ext_reset_pin_n(ext_reset_pin_n), .sub_clk(div_ff[3]),
    .osc_clk(div_ff[1]), .power_mode(power_mode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_reset_n(chip_reset_n),
    .watchdog_reset_flag(watchdog_reset_flag), .watchdog_running(watchdog_running)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, dat};
    repeat (20)
    begin
      @(posedge core_clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    rd_val = wb_dat_o[7:0];
    chk("ack", {7'h00, wb_ack_o}, 8'h01);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rd(input string nm, input logic [3:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00);
    chk(nm, rd_val, exp);
  endtask

  task automatic wait_pulse();
    t_start = 0;
    while (chip_reset_n === 1'b1 && t_start < 3000)
    begin
      @(posedge core_clk);
      t_start++;
    end
    t_low = 0;
    while (chip_reset_n !== 1'b1 && t_low < 3000)
    begin
      @(posedge core_clk);
      t_low++;
    end
    chk("pulse length", {7'h00, t_low >= 28 && t_low <= 40}, 8'h01);
  endtask

  task automatic run_modes(input logic [5:0] ok);
    for (int m = 0; m < 6; m++)
    begin
      power_mode <= m[2:0];
      @(posedge core_clk);
      @(posedge core_clk);
      chk("mode run", {7'h00, watchdog_running}, {7'h00, ok[m]});
    end
    power_mode <= 3'h0;
    @(posedge core_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    #80000;
    err_total++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    rd("ctrl", `WDRT_OFF_CTRL, 8'hAA);
    rd("count", `WDRT_OFF_COUNT, 8'h00);
    rd("stop", `WDRT_OFF_CLKSTOP, 8'hFF);
    rd("psel", `WDRT_OFF_PORTSEL, 8'h00);
    wr(4'h2, 8'hFF);
    rd("unmapped", 4'h2, 8'h00);
    wr(`WDRT_OFF_COUNT, 8'h55);
    rd("count locked", `WDRT_OFF_COUNT, 8'h00);
    wr(`WDRT_OFF_CTRL, 8'h5F);
    rd("ctrl mixed", `WDRT_OFF_CTRL, 8'hFA);
    wr(`WDRT_OFF_COUNT, 8'hFE);
    rd("count load", `WDRT_OFF_COUNT, 8'hFE);
    wr(`WDRT_OFF_CTRL, 8'hF7);
    rd("ctrl on", `WDRT_OFF_CTRL, 8'hFE);
    chk("running", {7'h00, watchdog_running}, 8'h01);
    wait_pulse();
    chk("sys delay", {7'h00, t_start < 24}, 8'h01);
    rd("ctrl after", `WDRT_OFF_CTRL, 8'hAB);
    wr(`WDRT_OFF_CTRL, 8'hFC);
    rd("flag kept", `WDRT_OFF_CTRL, 8'hAB);
    wr(`WDRT_OFF_CTRL, 8'h5F);
    wr(`WDRT_OFF_CTRL, 8'hFC);
    rd("flag clear", `WDRT_OFF_CTRL, 8'hFA);
    wr(`WDRT_OFF_COUNT, 8'h00);
    wr(`WDRT_OFF_CTRL, 8'hF7);
    repeat (40) @(posedge core_clk);
    wr(`WDRT_OFF_CTRL, 8'hF3);
    chk("stopped", {7'h00, watchdog_running}, 8'h00);
    bus(1'b0, `WDRT_OFF_COUNT, 8'h00);
    hold_val = rd_val;
    rd("count now", `WDRT_OFF_COUNT, hold_val);
    chk("counted", {7'h00, hold_val > 8'h02}, 8'h01);
    repeat (40) @(posedge core_clk);
    rd("count held", `WDRT_OFF_COUNT, hold_val);
    wr(`WDRT_OFF_CTRL, 8'hF7);
    wr(`WDRT_OFF_CLKSTOP, 8'hFB);
    rd("stop stored", `WDRT_OFF_CLKSTOP, 8'hFB);
    chk("standby run", {7'h00, watchdog_running}, 8'h01);
    wr(`WDRT_OFF_CTRL, 8'hF3);
    chk("standby off", {7'h00, watchdog_running}, 8'h00);
    wr(`WDRT_OFF_CLKSTOP, 8'hFF);
    wr(`WDRT_OFF_COUNT, 8'h00);
    wr(`WDRT_OFF_CTRL, 8'hF7);
    run_modes(6'b000011);
    wr(`WDRT_OFF_PORTSEL, 8'h20);
    run_modes(6'b001011);
    wr(`WDRT_OFF_COUNT, 8'hFE);
    wait_pulse();
    chk("sub delay", {7'h00, t_start > 40}, 8'h01);
    chk("flag", {7'h00, watchdog_reset_flag}, 8'h01);
    ext_reset_pin_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("pin reset", {7'h00, chip_reset_n}, 8'h00);
    ext_reset_pin_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd("ctrl pin", `WDRT_OFF_CTRL, 8'hAA);
    test_done();
  end
endmodule

// ===== wdrt_chk.sv
// wdrt_chk.sv: port-level assertions for the watchdog reset timer
// assumes: bound to the design top; osc_clk is slow against core_clk
`timescale 1ns/1ps
`include "wdrt_map.vh"
module wdrt_chk
#(
  parameter SYS_DIV   = 8192,
  parameter SUB_DIV   = 32,
  parameter RST_PULSE = 512
)
(
  input logic        core_clk,
  input logic        arst_n,
  input logic        ext_reset_pin_n,
  input logic        sub_clk,
  input logic        osc_clk,
  input logic [2:0]  power_mode,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [3:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        chip_reset_n,
  input logic        watchdog_reset_flag,
  input logic        watchdog_running
);
  logic        osc_d_ff;
  logic [15:0] osc_cnt_ff;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // oscillator rises seen while the chip reset is low
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_d_ff   <= 1'b0;
      osc_cnt_ff <= 16'h0000;
    end
    else
    begin
      osc_d_ff   <= osc_clk;
      osc_cnt_ff <= chip_reset_n ? 16'h0000 : osc_cnt_ff + {15'h0000, osc_clk & ~osc_d_ff};
    end
  end

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_guard_read_one: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `WDRT_OFF_CTRL |->
    (wb_dat_o & 32'hFFFFFFAA) == 32'h000000AA)
    else $error("guard bits of control read not one");
  a_flag_with_pulse: assert property ($rose(watchdog_reset_flag) |-> ##[0:3] !chip_reset_n)
    else $error("flag set without internal reset");
  a_pulse_length: assert property ($rose(chip_reset_n) && $past(ext_reset_pin_n, 12) |->
    osc_cnt_ff >= RST_PULSE - 1 && osc_cnt_ff <= RST_PULSE + 1)
    else $error("internal reset pulse length wrong");
  a_pin_resets_chip: assert property (!ext_reset_pin_n [*4] |-> !chip_reset_n)
    else $error("reset pin did not reach chip reset");
  a_pin_clears_flag: assert property (!ext_reset_pin_n [*5] |-> !watchdog_reset_flag)
    else $error("reset pin did not clear flag");
  a_halt_modes: assert property (power_mode inside {3'h2, 3'h4, 3'h5} |-> !watchdog_running)
    else $error("running in a halting mode");
  a_run_modes: assert property (watchdog_running |-> power_mode inside {3'h0, 3'h1, 3'h3})
    else $error("running in a mode that does not allow it");
  a_pulse_clears_enable: assert property (!chip_reset_n [*2] |-> !watchdog_running)
    else $error("enable survived internal reset");
endmodule

bind wdrt_watchdog_reset_timer wdrt_chk #(.SYS_DIV(SYS_DIV), .SUB_DIV(SUB_DIV), .RST_PULSE(RST_PULSE)) u_wdrt_chk
(
  .core_clk(core_clk), .arst_n(arst_n), .ext_reset_pin_n(ext_reset_pin_n), .sub_clk(sub_clk),
  .osc_clk(osc_clk), .power_mode(power_mode), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chip_reset_n(chip_reset_n),
  .watchdog_reset_flag(watchdog_reset_flag), .watchdog_running(watchdog_running)
);

// ===== wdrt_map.vh
// wdrt_map.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the watchdog design file, the checker and the testbench
`ifndef WDRT_MAP_VH
`define WDRT_MAP_VH
// ----------------------------------------------------------------
// register byte offsets on the wishbone bus
// ----------------------------------------------------------------
`define WDRT_OFF_CTRL       4'h0
`define WDRT_OFF_COUNT      4'h4
`define WDRT_OFF_CLKSTOP    4'h8
`define WDRT_OFF_PORTSEL    4'hC
// ----------------------------------------------------------------
// control/status, clock-stop and port-select field positions
// ----------------------------------------------------------------
`define WDRT_B_CWE_GUARD    7
`define WDRT_B_CWE          6
`define WDRT_B_RWE_GUARD    5
`define WDRT_B_RWE          4
`define WDRT_B_EN_GUARD     3
`define WDRT_B_EN           2
`define WDRT_B_FLAG_GUARD   1
`define WDRT_B_FLAG         0
`define WDRT_B_STANDBY      2
`define WDRT_B_CLKSEL       5
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDRT_RST_COUNT      8'h00
`define WDRT_RST_CLKSTOP    8'hFF
`define WDRT_RST_PORTSEL    8'h00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDRT_SYS_DIV        8192
`define WDRT_SUB_DIV        32
`define WDRT_RST_PULSE      512
`endif

// ===== wdrt_watchdog_reset_timer.v
// wdrt_watchdog_reset_timer.v: 8-bit watchdog with chip reset pulse, wishbone slave
// assumes: sub_clk and osc_clk are slow free-running levels sampled on core_clk;
// power mode inputs come from the chip's mode controller on core_clk.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "wdrt_map.vh"

module wdrt_watchdog_reset_timer
#(
  parameter SYS_DIV    = `WDRT_SYS_DIV,
  parameter SUB_DIV    = `WDRT_SUB_DIV,
  parameter RST_PULSE  = `WDRT_RST_PULSE
)
(
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        ext_reset_pin_n,
  input  wire        sub_clk,
  input  wire        osc_clk,
  input  wire [2:0]  power_mode,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        chip_reset_n,
  output wire        watchdog_reset_flag,
  output wire        watchdog_running
);

// ----------------------------------------------------------------
// power modes
// ----------------------------------------------------------------
localparam [2:0] MODE_ACTIVE    = 3'h0;
localparam [2:0] MODE_SLEEP     = 3'h1;
localparam [2:0] MODE_WATCH     = 3'h2;
localparam [2:0] MODE_SUBACTIVE = 3'h3;
localparam [2:0] MODE_SUBSLEEP  = 3'h4;
localparam [2:0] MODE_STANDBY   = 3'h5;

// ----------------------------------------------------------------
// reset pulse states
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE  = 2'h0;
localparam [1:0] ST_DELAY = 2'h1;
localparam [1:0] ST_PULSE = 2'h2;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg        counter_write_enable_ff;
reg        register_write_enable_ff;
reg        watchdog_enable_ff;
reg        watchdog_reset_flag_ff;
reg  [7:0] watchdog_counter_ff;
reg  [7:0] module_clock_stop_two_ff;
reg  [7:0] port_three_function_select_ff;
reg  [12:0] sys_div_ff;
reg  [4:0]  sub_div_ff;
reg  [1:0]  pst_ff;
reg  [9:0]  pulse_cnt_ff;
reg  [2:0]  pin_sync_ff;
reg  [2:0]  sub_sync_ff;
reg  [2:0]  osc_sync_ff;
reg         pin_reset_ff;

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
// stages 0 and 1 synchronise; stage 2 only serves edge detection
// pin chain resets high so no false pin reset follows release
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    pin_sync_ff <= 3'h7;
    sub_sync_ff <= 3'h0;
    osc_sync_ff <= 3'h0;
  end
  else
  begin
    pin_sync_ff <= {pin_sync_ff[1:0], ext_reset_pin_n};
    sub_sync_ff <= {sub_sync_ff[1:0], sub_clk};
    osc_sync_ff <= {osc_sync_ff[1:0], osc_clk};
  end
end

wire sub_rise = sub_sync_ff[1] & ~sub_sync_ff[2];
wire osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];
wire pin_low  = ~pin_sync_ff[1];

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
// ack high blocks a second take while the master still holds the request
wire       bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire       wr_lane0  = bus_req & wb_we_i & wb_sel_i[0];
wire [7:0] wd        = wb_dat_i[7:0];
wire       sel_ctrl  = (wb_adr_i == `WDRT_OFF_CTRL);
wire       sel_count = (wb_adr_i == `WDRT_OFF_COUNT);
wire       sel_stop  = (wb_adr_i == `WDRT_OFF_CLKSTOP);
wire       sel_port  = (wb_adr_i == `WDRT_OFF_PORTSEL);
wire       clk_sel   = port_three_function_select_ff[`WDRT_B_CLKSEL];
wire       standby_bit = module_clock_stop_two_ff[`WDRT_B_STANDBY];

// ----------------------------------------------------------------
// operating condition
// ----------------------------------------------------------------
reg mode_runs;
always @*
begin
  case (power_mode)
    MODE_ACTIVE:    mode_runs = 1'b1;
    MODE_SLEEP:     mode_runs = 1'b1;
    MODE_SUBACTIVE: mode_runs = clk_sel;
    default:        mode_runs = 1'b0;
  endcase
end

wire in_standby = ~standby_bit & ~watchdog_enable_ff;
// halt and hold in low modes
wire live       = mode_runs & ~in_standby;
wire wr_ok      = wr_lane0 & live;

// ----------------------------------------------------------------
// clock dividers and count tick
// ----------------------------------------------------------------
// system divider free-runs: the first period after enable may be short
// by up to SYS_DIV - 1 input clocks, which the software margin must absorb
wire sys_tick = (sys_div_ff == SYS_DIV - 1);
wire sub_tick = sub_rise & (sub_div_ff == SUB_DIV - 1);

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    sys_div_ff <= 13'h0000;
    sub_div_ff <= 5'h00;
  end
  else
  begin
    sys_div_ff <= sys_tick ? 13'h0000 : sys_div_ff + 13'h0001;
    if (sub_rise)
      sub_div_ff <= (sub_div_ff == SUB_DIV - 1) ? 5'h00 : sub_div_ff + 5'h01;
  end
end

wire count_tick = clk_sel ? sub_tick : sys_tick;
wire count_en   = watchdog_enable_ff & live & count_tick;
wire overflow   = count_en & (watchdog_counter_ff == 8'hFF) & (pst_ff == ST_IDLE);
wire ref_edge   = clk_sel ? sub_rise : 1'b1;

// ----------------------------------------------------------------
// reset pulse sequencer
// ----------------------------------------------------------------
// delay state holds the overflow for one reference clock;
// the pulse counter restarts on every entry to the pulse state
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    pst_ff       <= ST_IDLE;
    pulse_cnt_ff <= 10'h000;
  end
  else
  begin
    case (pst_ff)
      ST_IDLE:
      begin
        if (overflow)
          pst_ff <= ST_DELAY;
      end
      ST_DELAY:
      begin
        if (ref_edge)
        begin
          pst_ff       <= ST_PULSE;
          pulse_cnt_ff <= 10'h000;
        end
      end
      ST_PULSE:
      begin
        if (osc_rise)
        begin
          if (pulse_cnt_ff == RST_PULSE - 1)
            pst_ff <= ST_IDLE;
          pulse_cnt_ff <= pulse_cnt_ff + 10'h001;
        end
      end
      default: pst_ff <= ST_IDLE;
    endcase
  end
end

assign chip_reset_n = ~(pst_ff == ST_PULSE) & ~pin_reset_ff;
wire   wd_reset     = (pst_ff == ST_PULSE);
assign watchdog_reset_flag = watchdog_reset_flag_ff;
assign watchdog_running    = watchdog_enable_ff & live;

// ----------------------------------------------------------------
// external pin reset
// ----------------------------------------------------------------
// one extra stage keeps the pin reset glitch-free on chip_reset_n
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
    pin_reset_ff <= 1'b0;
  else
    pin_reset_ff <= pin_low;
end

// ----------------------------------------------------------------
// control/status register
// ----------------------------------------------------------------
// pin reset outranks the pulse so the flag reads 0 after a pin reset, or 1 if a pulse is still running when the pin is released;
// the pulse outranks any software write landing in the same cycle
wire cw = wr_ok & sel_ctrl;
wire rwe_ok = cw & register_write_enable_ff;

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    counter_write_enable_ff  <= 1'b0;
    register_write_enable_ff <= 1'b0;
    watchdog_enable_ff       <= 1'b0;
    watchdog_reset_flag_ff   <= 1'b0;
  end
  else if (pin_reset_ff)
  begin
    counter_write_enable_ff  <= 1'b0;
    register_write_enable_ff <= 1'b0;
    watchdog_enable_ff       <= 1'b0;
    watchdog_reset_flag_ff   <= 1'b0;
  end
  else if (wd_reset)
  begin
    counter_write_enable_ff  <= 1'b0;
    register_write_enable_ff <= 1'b0;
    watchdog_enable_ff       <= 1'b0;
    watchdog_reset_flag_ff   <= 1'b1;
  end
  else
  begin
    if (cw & ~wd[`WDRT_B_CWE_GUARD])
      counter_write_enable_ff <= wd[`WDRT_B_CWE];
    if (cw & ~wd[`WDRT_B_RWE_GUARD])
      register_write_enable_ff <= wd[`WDRT_B_RWE];
    if (rwe_ok & ~wd[`WDRT_B_EN_GUARD])
      watchdog_enable_ff <= wd[`WDRT_B_EN];
    if (rwe_ok & ~wd[`WDRT_B_FLAG_GUARD] & ~wd[`WDRT_B_FLAG])
      watchdog_reset_flag_ff <= 1'b0;
  end
end

// ----------------------------------------------------------------
// counter and side registers
// ----------------------------------------------------------------
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    watchdog_counter_ff           <= `WDRT_RST_COUNT;
    module_clock_stop_two_ff      <= `WDRT_RST_CLKSTOP;
    port_three_function_select_ff <= `WDRT_RST_PORTSEL;
  end
  else if (pin_reset_ff | wd_reset)
  begin
    watchdog_counter_ff           <= `WDRT_RST_COUNT;
    module_clock_stop_two_ff      <= `WDRT_RST_CLKSTOP;
    port_three_function_select_ff <= `WDRT_RST_PORTSEL;
  end
  else
  begin
    // a permitted load outranks a count tick in the same cycle
    // permitted load
    if (wr_ok & sel_count & counter_write_enable_ff)
      watchdog_counter_ff <= wd;
    else if (count_en)
      watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
    if (wr_lane0 & sel_stop)
      module_clock_stop_two_ff <= {4'hF, wd[3:0]};
    if (wr_lane0 & sel_port)
      port_three_function_select_ff <= wd;
  end
end

// ----------------------------------------------------------------
// bus answer
// ----------------------------------------------------------------
// unmapped offsets read zero and are still acknowledged
reg [7:0] rd_byte;
always @*
begin
  rd_byte = 8'h00;
  if (sel_ctrl)
    rd_byte = {1'b1, counter_write_enable_ff, 1'b1, register_write_enable_ff,
               1'b1, watchdog_enable_ff, 1'b1, watchdog_reset_flag_ff};
  else if (sel_count)
    rd_byte = watchdog_counter_ff;
  else if (sel_stop)
    rd_byte = module_clock_stop_two_ff;
  else if (sel_port)
    rd_byte = port_three_function_select_ff;
end

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end
  else
  begin
    wb_ack_o <= bus_req;
    if (bus_req & ~wb_we_i)
      wb_dat_o <= {24'h000000, rd_byte};
  end
end

endmodule
